// >>> pkg/wdt_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the watchdog
// Assumes: 32-bit register port, byte offsets, one 125 MHz clock
// Notes: Definitions only
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define WDT_OFF_CTRL 4'h0
`define WDT_OFF_KEY 4'h4

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define WDT_BIT_RST_FLAG 31
`define WDT_BIT_RST_EN 11
`define WDT_BIT_INT_EN 10
`define WDT_BIT_INT_FLAG 9
`define WDT_BIT_EN 8
`define WDT_RST_SEL_MSB 7
`define WDT_RST_SEL_LSB 4
`define WDT_INT_SEL_MSB 3
`define WDT_INT_SEL_LSB 0
`define WDT_KEY_MSB 7

// ----------------------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------------------
`define WDT_SEL_RESET 4'h0
`define WDT_KEY_RESET 8'h00
`define WDT_KEY_FIRST 8'hA5
`define WDT_KEY_SECOND 8'h5A

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDT_CLK_PERIOD_NS 8
`define WDT_MIN_EXP 16
`define WDT_RST_HOLD 4'h8

`endif

// >>> pkg/wdt_pkg.sv
// Purpose: Types shared by the watchdog modules
// Assumes: Nothing
// Notes: Constants live in wdt_defs.svh
package wdt_pkg;

   // Register port request, one access per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } wdt_req_t;

   // Period expiry pulses from the counter
   typedef struct packed {
      logic int_hit;
      logic rst_hit;
   } wdt_hit_t;

   typedef enum logic [0:0] {
      KEY_IDLE = 1'b0,
      KEY_ARMED = 1'b1
   } wdt_key_state_t;

endpackage : wdt_pkg

// >>> src/wdt_counter.sv
// Purpose: Free-running watchdog counter with two period comparators
// Assumes: Clear has priority over run
// Notes: Hit pulses are registered, one cycle after the match
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module wdt_counter #(
   parameter int MIN_EXP = `WDT_MIN_EXP
) (
   // Clock and control
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic run_in,
   // Period selects
   input wire logic [3:0] int_sel_in,
   input wire logic [3:0] rst_sel_in,
   // Expiry pulses
   output wdt_pkg::wdt_hit_t hit_out
);

   logic [31:0] cnt_ff;
   logic [31:0] int_mask;
   logic [31:0] rst_mask;

   // ------------------------------------------------------------------------
   // Period decode
   // ------------------------------------------------------------------------
   function automatic logic [31:0] period_mask(input logic [3:0] sel);
      int exp_v;
      exp_v = MIN_EXP + 15 - int'(sel);
      period_mask = ~(32'hFFFF_FFFF << exp_v);
   endfunction : period_mask

   assign int_mask = period_mask(int_sel_in);
   assign rst_mask = period_mask(rst_sel_in);

   // ------------------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         cnt_ff <= 32'h0000_0000;
      end else if (run_in) begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         hit_out <= '0;
      end else begin
         hit_out.int_hit <= run_in && (cnt_ff == int_mask);
         hit_out.rst_hit <= run_in && (cnt_ff == rst_mask);
      end
   end

endmodule : wdt_counter
`default_nettype wire

// >>> src/wdt_key_seq.sv
// Purpose: Ordered key pair detector for restart and enable unlock
// Assumes: One key write per cycle at most
// Notes: Done pulse comes one cycle after the second key write
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module wdt_key_seq (
   // Clock and clear
   input wire logic clk_in,
   input wire logic clr_in,
   // Key writes
   input wire logic wr_in,
   input wire logic [7:0] key_in,
   // Sequence complete
   output logic done_out
);

   wdt_pkg::wdt_key_state_t state_ff;

   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         state_ff <= wdt_pkg::KEY_IDLE;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (wr_in) begin
            case (state_ff)
               wdt_pkg::KEY_IDLE: begin
                  if (key_in == `WDT_KEY_FIRST) begin
                     state_ff <= wdt_pkg::KEY_ARMED;
                  end
               end
               wdt_pkg::KEY_ARMED: begin
                  if (key_in == `WDT_KEY_SECOND) begin
                     state_ff <= wdt_pkg::KEY_IDLE;
                     done_out <= 1'b1;
                  end else if (key_in == `WDT_KEY_FIRST) begin
                     state_ff <= wdt_pkg::KEY_ARMED;
                  end else begin
                     state_ff <= wdt_pkg::KEY_IDLE;
                  end
               end
               default: begin
                  state_ff <= wdt_pkg::KEY_IDLE;
               end
            endcase
         end
      end
   end

endmodule : wdt_key_seq
`default_nettype wire

// >>> src/wdt_top.sv
// Purpose: Watchdog with interrupt, reset request and protected enable
// Assumes: RST_IN is power-on reset; SYS_RST_IN is any other reset
// Notes: Register port answers reads one cycle later
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module wdt_top #(
   parameter int MIN_EXP = `WDT_MIN_EXP
) (
   // Clock and resets
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic SYS_RST_IN,
   // Register port
   input wire wdt_pkg::wdt_req_t REQ_IN,
   output logic [31:0] RDATA_OUT,
   output logic RVALID_OUT,
   // Events and status
   output logic IRQ_OUT,
   output logic SYS_RST_REQ_OUT,
   output logic ENABLED_OUT
);

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   logic sys_rst_meta_ff;
   logic sys_rst_sync_ff;
   logic sel_ctrl;
   logic sel_key;
   logic wr_ctrl;
   logic wr_key;
   logic key_done;
   logic key_clr;
   logic cnt_clr;
   logic int_evt;
   logic rst_evt;
   logic en_ff;
   logic unlock_ff;
   logic rst_en_ff;
   logic int_en_ff;
   logic int_flag_ff;
   logic rst_flag_ff;
   logic [3:0] int_sel_ff;
   logic [3:0] rst_sel_ff;
   logic [7:0] key_ff;
   logic rst_req_ff;
   logic [3:0] hold_cnt_ff;
   logic [31:0] nxt_rdata;
   wdt_pkg::wdt_hit_t hit;

   // ------------------------------------------------------------------------
   // Other-reset synchroniser
   // ------------------------------------------------------------------------
   // Other resets may come from any source, so sync before use
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sys_rst_meta_ff <= 1'b0;
         sys_rst_sync_ff <= 1'b0;
      end else begin
         sys_rst_meta_ff <= SYS_RST_IN;
         sys_rst_sync_ff <= sys_rst_meta_ff;
      end
   end

   // ------------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------------
   assign sel_ctrl = (REQ_IN.addr == `WDT_OFF_CTRL);
   assign sel_key = (REQ_IN.addr == `WDT_OFF_KEY);
   assign wr_ctrl = REQ_IN.wr && sel_ctrl;
   assign wr_key = REQ_IN.wr && sel_key;

   // ------------------------------------------------------------------------
   // Key sequence and counter
   // ------------------------------------------------------------------------
   assign key_clr = RST_IN || sys_rst_sync_ff;

   wdt_key_seq u_key (
      .clk_in(CLK_IN),
      .clr_in(key_clr),
      .wr_in(wr_key),
      .key_in(REQ_IN.wdata[`WDT_KEY_MSB:0]),
      .done_out(key_done)
   );

   // Disabled counter is held at zero so re-enable starts a full period
   assign cnt_clr = RST_IN || sys_rst_sync_ff || rst_req_ff || key_done || !en_ff;

   wdt_counter #(
      .MIN_EXP(MIN_EXP)
   ) u_cnt (
      .clk_in(CLK_IN),
      .clr_in(cnt_clr),
      .run_in(en_ff),
      .int_sel_in(int_sel_ff),
      .rst_sel_in(rst_sel_ff),
      .hit_out(hit)
   );

   // Hits are gated by enable so a late pulse after disable is dropped
   assign int_evt = hit.int_hit && en_ff;
   assign rst_evt = hit.rst_hit && en_ff && rst_en_ff && !rst_req_ff;

   // ------------------------------------------------------------------------
   // Enable and unlock
   // ------------------------------------------------------------------------
   // Unlock lasts until the next write to the control or key register
   always_ff @(posedge CLK_IN) begin
      if (RST_IN || sys_rst_sync_ff) begin
         unlock_ff <= 1'b0;
      end else if (wr_ctrl || wr_key) begin
         unlock_ff <= 1'b0;
      end else if (key_done) begin
         unlock_ff <= 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         if (!REQ_IN.wdata[`WDT_BIT_EN]) begin
            en_ff <= 1'b0;
         end else if (unlock_ff || key_done) begin
            en_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rst_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         rst_en_ff <= REQ_IN.wdata[`WDT_BIT_RST_EN];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         int_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         int_en_ff <= REQ_IN.wdata[`WDT_BIT_INT_EN];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         int_sel_ff <= `WDT_SEL_RESET;
         rst_sel_ff <= `WDT_SEL_RESET;
      end else if (wr_ctrl) begin
         int_sel_ff <= REQ_IN.wdata[`WDT_INT_SEL_MSB:`WDT_INT_SEL_LSB];
         rst_sel_ff <= REQ_IN.wdata[`WDT_RST_SEL_MSB:`WDT_RST_SEL_LSB];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         key_ff <= `WDT_KEY_RESET;
      end else if (wr_key) begin
         key_ff <= REQ_IN.wdata[`WDT_KEY_MSB:0];
      end
   end

   // ------------------------------------------------------------------------
   // Interrupt flag
   // ------------------------------------------------------------------------
   // Expiry in the clearing cycle wins
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         int_flag_ff <= 1'b0;
      end else if (int_evt) begin
         int_flag_ff <= 1'b1;
      end else if (wr_ctrl && REQ_IN.wdata[`WDT_BIT_INT_FLAG]) begin
         int_flag_ff <= 1'b0;
      end
   end

   assign IRQ_OUT = int_flag_ff && int_en_ff;

   // ------------------------------------------------------------------------
   // Reset request and cause flag
   // ------------------------------------------------------------------------
   // Request is stretched so a slow reset controller cannot miss it
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rst_req_ff <= 1'b0;
         hold_cnt_ff <= 4'h0;
      end else if (rst_evt) begin
         rst_req_ff <= 1'b1;
         hold_cnt_ff <= `WDT_RST_HOLD - 4'h1;
      end else if (rst_req_ff) begin
         if (hold_cnt_ff == 4'h0) begin
            rst_req_ff <= 1'b0;
         end else begin
            hold_cnt_ff <= hold_cnt_ff - 4'h1;
         end
      end
   end

   assign SYS_RST_REQ_OUT = rst_req_ff;

   // Only power-on clears it by hardware; other resets keep it
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rst_flag_ff <= 1'b0;
      end else if (rst_evt) begin
         rst_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         rst_flag_ff <= REQ_IN.wdata[`WDT_BIT_RST_FLAG];
      end
   end

   assign ENABLED_OUT = en_ff;

   // ------------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------------
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (sel_ctrl) begin
         nxt_rdata[`WDT_BIT_RST_FLAG] = rst_flag_ff;
         nxt_rdata[`WDT_BIT_RST_EN] = rst_en_ff;
         nxt_rdata[`WDT_BIT_INT_EN] = int_en_ff;
         nxt_rdata[`WDT_BIT_INT_FLAG] = int_flag_ff;
         nxt_rdata[`WDT_BIT_EN] = en_ff;
         nxt_rdata[`WDT_RST_SEL_MSB:`WDT_RST_SEL_LSB] = rst_sel_ff;
         nxt_rdata[`WDT_INT_SEL_MSB:`WDT_INT_SEL_LSB] = int_sel_ff;
      end else if (sel_key) begin
         nxt_rdata[`WDT_KEY_MSB:0] = key_ff;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         RDATA_OUT <= 32'h0000_0000;
         RVALID_OUT <= 1'b0;
      end else begin
         RVALID_OUT <= REQ_IN.rd;
         if (REQ_IN.rd) begin
            RDATA_OUT <= nxt_rdata;
         end
      end
   end

endmodule : wdt_top
`default_nettype wire

// >>> verification/wdt_properties.sv
// Purpose: Port checks for the watchdog
// Assumes: One clock, RST_IN is power-on reset
// Notes: Bound into wdt_top
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module wdt_properties #(
   parameter int MIN_EXP = `WDT_MIN_EXP
) (
   // Clock and resets
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic SYS_RST_IN,
   // Register port
   input wire wdt_pkg::wdt_req_t REQ_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic RVALID_OUT,
   // Events
   input wire logic IRQ_OUT,
   input wire logic SYS_RST_REQ_OUT,
   input wire logic ENABLED_OUT
);
   // ------
   // Key tracking
   // ------
   logic armed_ff;
   logic pair_ff;
   wire logic key_wr = REQ_IN.wr && REQ_IN.addr == `WDT_OFF_KEY;
   wire logic ctl_wr = REQ_IN.wr && REQ_IN.addr == `WDT_OFF_CTRL;
   wire logic en_wr = ctl_wr && REQ_IN.wdata[`WDT_BIT_EN] && pair_ff;
   wire logic off_wr = ctl_wr && !REQ_IN.wdata[`WDT_BIT_EN];
   // Laxer than the design: system reset ignored
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         armed_ff <= 1'b0;
         pair_ff <= 1'b0;
      end else if (REQ_IN.wr) begin
         armed_ff <= key_wr && REQ_IN.wdata[7:0] == `WDT_KEY_FIRST;
         pair_ff <= key_wr && REQ_IN.wdata[7:0] == `WDT_KEY_SECOND && armed_ff;
      end
   end
   // ------
   // Properties
   // ------
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   ctrl_read_a: assert property (REQ_IN.rd && REQ_IN.addr == `WDT_OFF_CTRL |=>
      RVALID_OUT && RDATA_OUT[30:12] == 19'h00000) else $error("control read wrong");
   key_read_a: assert property (REQ_IN.rd && REQ_IN.addr == `WDT_OFF_KEY |=>
      RVALID_OUT && RDATA_OUT[31:8] == 24'h000000) else $error("key read wrong");
   irq_fields_a: assert property (REQ_IN.rd && REQ_IN.addr == `WDT_OFF_CTRL && IRQ_OUT |=>
      RDATA_OUT[`WDT_BIT_INT_FLAG] && RDATA_OUT[`WDT_BIT_INT_EN]) else $error("irq without bits");
   irq_cause_a: assert property ($rose(IRQ_OUT) |->
      $past(ENABLED_OUT) || $past(REQ_IN.wr)) else $error("irq while stopped");
   rst_hold_a: assert property ($rose(SYS_RST_REQ_OUT) |->
      SYS_RST_REQ_OUT [*8] ##1 !SYS_RST_REQ_OUT) else $error("reset request length");
   rst_cause_a: assert property ($rose(SYS_RST_REQ_OUT) |->
      $past(ENABLED_OUT)) else $error("reset request while stopped");
   enable_key_a: assert property ($rose(ENABLED_OUT) |->
      $past(en_wr)) else $error("enable without key pair");
   disable_cause_a: assert property ($fell(ENABLED_OUT) |->
      $past(off_wr)) else $error("enable lost");
   por_clear_a: assert property (disable iff (1'b0) RST_IN |=>
      !ENABLED_OUT && !IRQ_OUT && !SYS_RST_REQ_OUT) else $error("power-on reset ignored");
   cover property ($rose(IRQ_OUT));
   cover property ($rose(SYS_RST_REQ_OUT));
   cover property ($rose(ENABLED_OUT));
endmodule : wdt_properties

bind wdt_top wdt_properties #(.MIN_EXP(MIN_EXP)) u_wdt_properties (.CLK_IN(CLK_IN),
   .RST_IN(RST_IN), .SYS_RST_IN(SYS_RST_IN), .REQ_IN(REQ_IN), .RDATA_OUT(RDATA_OUT),
   .RVALID_OUT(RVALID_OUT), .IRQ_OUT(IRQ_OUT), .SYS_RST_REQ_OUT(SYS_RST_REQ_OUT),
   .ENABLED_OUT(ENABLED_OUT));
`default_nettype wire

// >>> verification/wdt_cpu_model.sv
// Purpose: Processor side of the watchdog register port
// Assumes: One access at a time, driven 1 ns after the edge
// Notes: Idle lines carry inverted junk
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module wdt_cpu_model (
   // Clock
   input wire logic clk_in,
   // Register port
   output var wdt_pkg::wdt_req_t req_out,
   input wire logic [31:0] rdata_in,
   input wire logic rvalid_in
);
   // ------
   // Accesses
   // ------
   initial req_out = '0;
   task automatic put(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      #1 req_out = '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk_in);
      // Stale address and data would hide decode slips
      #1 req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : put
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      put(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic ok);
      put(1'b0, 1'b1, a, 32'h00000000);
      ok = rvalid_in;
      d = rdata_in;
   endtask : rd
   // Restart pair, also the unlock for the enable bit
   task automatic key_pair();
      wr(`WDT_OFF_KEY, 32'h000000A5);
      wr(`WDT_OFF_KEY, 32'h0000005A);
   endtask : key_pair
endmodule : wdt_cpu_model
`default_nettype wire

// >>> verification/tb_watchdog_timer_with_irq_and_reset.sv
// Purpose: Self-checking bench for the watchdog
// Assumes: MIN_EXP of 4 shortens every period
// Notes: Register traffic goes through the cpu model
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.svh"

module tb_watchdog_timer_with_irq_and_reset;
   // ------
   // Set-up
   // ------
   localparam int ME = 4;
   localparam int PF = 2 ** ME;
   localparam int PE = 2 ** (ME + 1);
   localparam logic [3:0] KA = `WDT_OFF_KEY;
   localparam logic [3:0] CA = `WDT_OFF_CTRL;
   localparam logic [31:0] CI = 32'h000005EF;
   localparam logic [31:0] CR = 32'h000009EF;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sys_rst = 1'b0;
   wdt_pkg::wdt_req_t req;
   logic [31:0] rdata;
   logic rvalid;
   logic irq;
   logic rst_req;
   logic enabled;
   int n_mismatch = 0;
   int checks_done = 0;
   int n;
   always #4 clk = ~clk;
   wdt_top #(.MIN_EXP(ME)) u_wdt_top (.CLK_IN(clk), .RST_IN(rst), .SYS_RST_IN(sys_rst),
      .REQ_IN(req), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .IRQ_OUT(irq),
      .SYS_RST_REQ_OUT(rst_req), .ENABLED_OUT(enabled));
   wdt_cpu_model u_wdt_cpu_model (.clk_in(clk), .req_out(req), .rdata_in(rdata),
      .rvalid_in(rvalid));
   // ------
   // Helpers
   // ------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic bchk(input string what, input logic s, input logic e);
      chk(what, {31'h0, s}, {31'h0, e});
   endtask : bchk
   task automatic win(input string what, input int v, input int lo, input int hi);
      bchk(what, v >= lo && v <= hi, 1'b1);
   endtask : win
   task automatic w(input logic [3:0] a, input logic [31:0] d);
      u_wdt_cpu_model.wr(a, d);
   endtask : w
   task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic ok;
      u_wdt_cpu_model.rd(a, d, ok);
      bchk(what, ok, 1'b1);
      chk(what, d, exp);
   endtask : rchk
   // Bounded wait for irq (0) or reset request (1)
   task automatic wait_ev(input logic pick, output int cnt);
      cnt = 0;
      while ((pick ? rst_req : irq) !== 1'b1) begin
         @(posedge clk);
         #1 cnt++;
         if (cnt > 200) begin
            n_mismatch++;
            $display("BAD event expected 1 seen 0");
            tally_and_finish();
         end
      end
   endtask : wait_ev
   task automatic quiet(input int k, input string what);
      logic hit;
      hit = 1'b0;
      repeat (k) begin
         @(posedge clk);
         #1 hit = hit | irq | rst_req;
      end
      bchk(what, hit, 1'b0);
   endtask : quiet
   // ------
   // Scenarios
   // ------
   task automatic t_regs();
      rchk("ctrl reset", CA, 32'h0);
      rchk("key reset", KA, 32'h0);
      w(CA, 32'hFFFFFFFF);
      bchk("enable refused", enabled, 1'b0);
      rchk("ctrl fields", CA, 32'h80000CFF);
      w(KA, 32'hFFFFFFFF);
      rchk("key fields", KA, 32'h000000FF);
      rchk("unmapped", 4'h8, 32'h0);
      w(CA, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_unlock();
      w(KA, 32'h000000A5);
      w(KA, 32'h00000033);
      w(KA, 32'h0000005A);
      w(CA, 32'h00000100);
      bchk("broken pair", enabled, 1'b0);
      w(KA, 32'h000000A5);
      u_wdt_cpu_model.key_pair();
      w(CA, 32'h00000100);
      bchk("rearmed pair", enabled, 1'b1);
      w(CA, 32'h0);
      bchk("disable", enabled, 1'b0);
      u_wdt_cpu_model.key_pair();
      w(KA, 32'h00000011);
      w(CA, 32'h00000100);
      bchk("late enable", enabled, 1'b0);
      $display("t_unlock done");
   endtask : t_unlock
   task automatic t_irq();
      u_wdt_cpu_model.key_pair();
      w(CA, CI);
      wait_ev(1'b0, n);
      win("irq delay", n, PF, PF + 5);
      rchk("irq flag", CA, CI | 32'h200);
      w(CA, CI | 32'h200);
      bchk("flag clear", irq, 1'b0);
      repeat (4) begin
         u_wdt_cpu_model.key_pair();
         quiet(8, "restarted");
      end
      u_wdt_cpu_model.key_pair();
      wait_ev(1'b0, n);
      win("restart delay", n, PF, PF + 5);
      w(CA, CI | 32'h200);
      u_wdt_cpu_model.key_pair();
      w(KA, 32'h000000A5);
      w(KA, 32'h00000033);
      w(KA, 32'h0000005A);
      wait_ev(1'b0, n);
      win("bad key delay", n + 6, PF, PF + 5);
      w(CA, (CI & ~32'h400) | 32'h200);
      u_wdt_cpu_model.key_pair();
      quiet(PF + 8, "masked irq");
      rchk("masked flag", CA, (CI & ~32'h400) | 32'h200);
      w(CA, CI);
      bchk("unmasked irq", irq, 1'b1);
      w(CA, 32'h0);
      $display("t_irq done");
   endtask : t_irq
   task automatic t_rst();
      u_wdt_cpu_model.key_pair();
      w(CA, CR);
      wait_ev(1'b1, n);
      win("reset delay", n, PE, PE + 5);
      repeat (9) @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      bchk("kept enable", enabled, 1'b1);
      wait_ev(1'b1, n);
      win("counter restart", n, PE, PE + 8);
      repeat (9) @(posedge clk);
      rchk("cause flag", CA, CR | 32'h80000200);
      w(CA, 32'h00000AEF);
      quiet(3 * PE, "stopped");
      u_wdt_cpu_model.key_pair();
      w(CA, CR);
      bchk("enabled", enabled, 1'b1);
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      bchk("por enable", enabled, 1'b0);
      rchk("por ctrl", CA, 32'h0);
      $display("t_rst done");
   endtask : t_rst
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_regs();
      t_unlock();
      t_irq();
      t_rst();
      tally_and_finish();
   end
endmodule : tb_watchdog_timer_with_irq_and_reset
`default_nettype wire
